// >>> src/hsq_map.svh
// Register map and constants of the homing sequencer.
// Assumes APB access with 32-bit data, one aligned word per register.
`ifndef HSQ_MAP_SVH
`define HSQ_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define HSQ_OFF_MODE      8'h00
`define HSQ_OFF_CMD       8'h04
`define HSQ_OFF_STATUS    8'h08
`define HSQ_OFF_OFFSET    8'h0C
`define HSQ_OFF_METHOD    8'h10
`define HSQ_OFF_SPD_SW    8'h14
`define HSQ_OFF_SPD_ZERO  8'h18
`define HSQ_OFF_ACCEL     8'h1C
`define HSQ_OFF_BLK_CUR   8'h20
`define HSQ_OFF_BLK_MS    8'h24
`define HSQ_OFF_POS       8'h28
`define HSQ_OFF_SPEED     8'h2C

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define HSQ_MODE_HOMING   8'h06
`define HSQ_CMD_START_BIT 4
`define HSQ_CMD_CL_BIT    0
`define HSQ_CMD_OPEN_BIT  1
`define HSQ_ST_B10        10
`define HSQ_ST_B12        12
`define HSQ_ST_B13        13
`define HSQ_MASK_NEG      0
`define HSQ_MASK_POS      1
`define HSQ_MASK_HOME     2
`define HSQ_M_CUR_POS     8'h23
`define HSQ_M_IDX_NEG     8'h21
`define HSQ_M_IDX_POS     8'h22

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HSQ_CLK_MHZ       250
`define HSQ_MS_CYCLES     (`HSQ_CLK_MHZ * 1000)
`define HSQ_MS_CNT_W      18

`endif

// >>> src/hsq_pkg.sv
// Types shared by the homing sequencer files.
// Assumes the map header is included where constants are needed.
package hsq_pkg;

  typedef enum logic [6:0] {
    HSQ_IDLE   = 7'h01,
    HSQ_SEARCH = 7'h02,
    HSQ_BACK   = 7'h04,
    HSQ_INDEX  = 7'h08,
    HSQ_BLOCK  = 7'h10,
    HSQ_DONE   = 7'h20,
    HSQ_ERROR  = 7'h40
  } hsq_state_type;

  typedef struct packed {
    logic       uses_index;
    logic       on_block;
    logic       dir_pos;
    logic       ref_limit;
    logic       ref_home;
    logic       edge_right;
    logic       valid;
  } hsq_plan_type;

  typedef struct packed {
    logic       home_sw;
    logic       neg_limit;
    logic       pos_limit;
    logic       index_pulse;
  } hsq_sense_type;

endpackage

// >>> src/hsq_ms_timer.sv
// Millisecond blocking timer of the homing sequencer.
// Assumes a 250 MHz clock; counts whole milliseconds while enabled.
`timescale 1ns/1ps
`include "hsq_map.svh"
module hsq_ms_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [15:0] period_ms_in,
  output logic             expired_out
);
  import hsq_pkg::*;

  logic [`HSQ_MS_CNT_W-1:0] tick_reg;
  logic [15:0]              ms_reg;

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_reg <= '0;
      ms_reg   <= '0;
    end else if (!run_in) begin
      tick_reg <= '0;
      ms_reg   <= '0;
    end else if (tick_reg == `HSQ_MS_CNT_W'(`HSQ_MS_CYCLES - 1)) begin
      tick_reg <= '0;
      if (ms_reg != 16'hFFFF) begin
        ms_reg <= ms_reg + 16'h0001;
      end
    end else begin
      tick_reg <= tick_reg + `HSQ_MS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= run_in && (ms_reg >= period_ms_in);
    end
  end

endmodule

// >>> src/hsq_homing.sv
// Homing sequencer: APB registers, method decode, travel state machine.
// Assumes synchronous switch, index and current inputs; one clock domain.
//
// Overview of operation
// - A rising edge of command bit 4 starts homing; clearing it aborts the run.
// - Status 13/12/10 reads 000 running, 001 idle, 010 homed, 011 done.
// - On error status reads 100 while turning, 101 at standstill.
// - Status bit 12 sets after the first fully completed run.
// - Bit 12 clears during later runs and on errors until next completion.
// - Home offset register holds zero-to-reference difference in user units.
// - Method number selects edge, block or index reference and direction.
// - Methods 1-14, 33, 34 use index; 17-30 same profiles without index.
// - Negative methods home on block; only the listed values are allowed.
// - Block homing only while closed-loop control is active.
// - Block detected when motor current exceeds the threshold.
// - Keep pushing against the block for the configured milliseconds.
// - Method 1 negative limit then index; method 2 positive limit.
// - Methods 3 and 4 use left home switch edge then index.
// - Methods 5 and 6 use right home switch edge then index.
// - Methods 7-10 watch positive limit, 11-14 negative, any start position.
// - Method 17 negative limit, 18 positive limit, no index.
// - Methods 19-22 act as 3-6 but stop at the switch edge.
// - Methods 23-26 watch positive side, 27-30 negative, no index.
// - Methods 33 and 34 reference the next index pulse only.
// - Method 35 takes present position, without operation enabled.
// - Separate speeds for switch search and index search.
`timescale 1ns/1ps
`include "hsq_map.svh"
module hsq_homing (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic [31:0]               prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire hsq_pkg::hsq_sense_type sense_in,
  input  wire logic [2:0]           input_special_function_mask_in,
  input  wire logic [15:0]          motor_current_in,
  input  wire logic                 op_enabled_in,
  input  wire logic                 step_in,
  output logic signed [31:0]        speed_out,
  output logic signed [31:0]        position_out,
  output logic                      homed_out
);
  import hsq_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]         operating_mode_select_reg;
  logic [15:0]        drive_command_word_reg;
  logic signed [31:0] home_offset_reg;
  logic signed [7:0]  homing_method_number_reg;
  logic [31:0]        spd_switch_reg;
  logic [31:0]        spd_zero_reg;
  logic [31:0]        homing_accel_reg;
  logic [15:0]        blk_current_reg;
  logic [15:0]        blk_ms_reg;
  logic [2:0]         code_reg;
  logic               ever_homed_reg;
  hsq_state_type      state_reg;
  hsq_plan_type       plan_reg;
  logic signed [31:0] target_speed_reg;
  logic               home_prev_reg;
  logic               start_prev_reg;
  logic               blk_run_reg;
  logic               blk_expired;

  // ----------------------------------------------------------------------
  // Method decode
  // ----------------------------------------------------------------------
  function automatic hsq_plan_type decode_method(
    input logic signed [7:0] m_in
  );
    hsq_plan_type p;
    logic [7:0]   a;
    logic [7:0]   b;
    p = '0;
    a = m_in[7] ? 8'(-m_in) : 8'(m_in);
    p.on_block = m_in[7];
    b = (a >= 8'h11 && a <= 8'h1E) ? a - 8'h10 : a;
    p.uses_index = (a <= 8'h0E) || a == `HSQ_M_IDX_NEG
                   || a == `HSQ_M_IDX_POS;
    case (b)
      8'h01, 8'h02: begin
        p.ref_limit = 1'b1;
        p.dir_pos   = (b == 8'h02);
        p.valid     = 1'b1;
      end
      8'h03, 8'h04, 8'h05, 8'h06: begin
        p.ref_home   = 1'b1;
        p.edge_right = (b >= 8'h05);
        p.dir_pos    = (b == 8'h03) || (b == 8'h05);
        p.valid      = !m_in[7] && !(b == 8'h03) || !m_in[7];
      end
      8'h07, 8'h08, 8'h09, 8'h0A: begin
        p.ref_home   = 1'b1;
        p.dir_pos    = 1'b1;
        p.edge_right = (b >= 8'h09);
        p.valid      = 1'b1;
      end
      8'h0B, 8'h0C, 8'h0D, 8'h0E: begin
        p.ref_home   = 1'b1;
        p.dir_pos    = 1'b0;
        p.edge_right = (b <= 8'h0C);
        p.valid      = 1'b1;
      end
      8'h21, 8'h22: begin
        p.dir_pos = (b == `HSQ_M_IDX_POS);
        p.valid   = !m_in[7];
      end
      8'h23: begin
        p.valid = !m_in[7];
      end
      default: begin
        p.valid = 1'b0;
      end
    endcase
    // Block homing excludes methods 3 to 6 and 19 to 22
    if (m_in[7] && b >= 8'h03 && b <= 8'h06) begin
      p.valid = 1'b0;
    end
    return p;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic wr_en;
  logic start_lvl;
  assign wr_en     = psel_in && penable_in && pwrite_in;
  assign start_lvl = drive_command_word_reg[`HSQ_CMD_START_BIT];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      operating_mode_select_reg <= 8'h00;
      drive_command_word_reg    <= 16'h0000;
      home_offset_reg           <= 32'sh0;
      homing_method_number_reg  <= 8'sh0;
      spd_switch_reg            <= 32'h0000_0000;
      spd_zero_reg              <= 32'h0000_0000;
      homing_accel_reg          <= 32'h0000_0001;
      blk_current_reg           <= 16'hFFFF;
      blk_ms_reg                <= 16'h0000;
    end else if (wr_en) begin
      case (paddr_in)
        `HSQ_OFF_MODE:     operating_mode_select_reg <= pwdata_in[7:0];
        `HSQ_OFF_CMD:      drive_command_word_reg <= pwdata_in[15:0];
        `HSQ_OFF_OFFSET:   home_offset_reg <= pwdata_in;
        `HSQ_OFF_METHOD:   homing_method_number_reg <= pwdata_in[7:0];
        `HSQ_OFF_SPD_SW:   spd_switch_reg <= pwdata_in;
        `HSQ_OFF_SPD_ZERO: spd_zero_reg <= pwdata_in;
        `HSQ_OFF_ACCEL:    homing_accel_reg <= pwdata_in;
        `HSQ_OFF_BLK_CUR:  blk_current_reg <= pwdata_in[15:0];
        `HSQ_OFF_BLK_MS:   blk_ms_reg <= pwdata_in[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in) begin
        prdata_out <= 32'h0000_0000;
        case (paddr_in)
          `HSQ_OFF_MODE:     prdata_out[7:0] <= operating_mode_select_reg;
          `HSQ_OFF_CMD:      prdata_out[15:0] <= drive_command_word_reg;
          `HSQ_OFF_STATUS: begin
            prdata_out[`HSQ_ST_B13] <= code_reg[2];
            prdata_out[`HSQ_ST_B12] <= code_reg[1];
            prdata_out[`HSQ_ST_B10] <= code_reg[0];
          end
          `HSQ_OFF_OFFSET:   prdata_out <= home_offset_reg;
          `HSQ_OFF_METHOD:   prdata_out <= 32'(homing_method_number_reg);
          `HSQ_OFF_SPD_SW:   prdata_out <= spd_switch_reg;
          `HSQ_OFF_SPD_ZERO: prdata_out <= spd_zero_reg;
          `HSQ_OFF_ACCEL:    prdata_out <= homing_accel_reg;
          `HSQ_OFF_BLK_CUR:  prdata_out[15:0] <= blk_current_reg;
          `HSQ_OFF_BLK_MS:   prdata_out[15:0] <= blk_ms_reg;
          `HSQ_OFF_POS:      prdata_out <= position_out;
          `HSQ_OFF_SPEED:    prdata_out <= speed_out;
          default:           pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Switch view and events
  // ----------------------------------------------------------------------
  logic home_sw;
  logic neg_lim;
  logic pos_lim;
  logic blocked;
  logic home_edge;
  logic start_rise;
  logic cl_active;
  logic fwd_lim;
  assign home_sw = sense_in.home_sw
                   && input_special_function_mask_in[`HSQ_MASK_HOME];
  assign neg_lim = sense_in.neg_limit
                   && input_special_function_mask_in[`HSQ_MASK_NEG];
  assign pos_lim = sense_in.pos_limit
                   && input_special_function_mask_in[`HSQ_MASK_POS];
  assign cl_active = drive_command_word_reg[`HSQ_CMD_CL_BIT];
  assign blocked = motor_current_in > blk_current_reg;
  assign home_edge  = home_sw != home_prev_reg;
  assign start_rise = start_lvl && !start_prev_reg;
  // Reference end of travel: a limit switch, or a block in block mode
  assign fwd_lim = plan_reg.on_block ? blocked
                   : (plan_reg.dir_pos ? pos_lim : neg_lim);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      home_prev_reg  <= 1'b0;
      start_prev_reg <= 1'b0;
    end else begin
      home_prev_reg  <= home_sw;
      start_prev_reg <= start_lvl;
    end
  end

  hsq_ms_timer u_blk_timer (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .run_in       (blk_run_reg),
    .period_ms_in (blk_ms_reg),
    .expired_out  (blk_expired)
  );

  // ----------------------------------------------------------------------
  // Homing state machine
  // ----------------------------------------------------------------------
  logic run_ok;
  logic abort;
  logic standstill;
  assign run_ok = operating_mode_select_reg == `HSQ_MODE_HOMING;
  assign abort  = !start_lvl || !run_ok;
  assign standstill = speed_out == 32'sh0;

  logic plan_ok;
  logic cur_pos;
  logic home_hit;
  logic at_rest;
  logic ref_hit;
  assign plan_ok  = plan_reg.valid && !(plan_reg.on_block && !cl_active);
  assign cur_pos  = homing_method_number_reg == 8'(`HSQ_M_CUR_POS);
  assign home_hit = plan_reg.ref_home && home_edge
                    && (home_sw ^ plan_reg.edge_right);
  assign at_rest  = standstill && target_speed_reg == 32'sh0;
  // Completion edge: the counter is loaded on it, not a cycle later
  assign ref_hit  = !abort
                    && (state_reg == HSQ_INDEX && sense_in.index_pulse
                        || !plan_reg.uses_index
                           && (state_reg == HSQ_SEARCH && plan_ok
                               && (cur_pos || home_hit
                                   || fwd_lim && plan_reg.ref_limit
                                      && !plan_reg.on_block)
                               || state_reg == HSQ_BACK && home_edge
                               || state_reg == HSQ_BLOCK && blk_expired
                                  && plan_reg.ref_limit));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= HSQ_IDLE;
      plan_reg    <= '0;
      blk_run_reg <= 1'b0;
    end else begin
      case (state_reg)
        HSQ_IDLE: begin
          if (start_rise && run_ok) begin
            plan_reg <= decode_method(homing_method_number_reg);
            state_reg <= HSQ_SEARCH;
          end
        end
        HSQ_SEARCH: begin
          if (abort) begin
            state_reg <= HSQ_IDLE;
          end else if (!plan_ok) begin
            state_reg <= HSQ_ERROR;
          end else if (homing_method_number_reg == 8'(`HSQ_M_CUR_POS)) begin
            state_reg <= HSQ_DONE;
          end else if (!plan_reg.ref_limit && !plan_reg.ref_home) begin
            state_reg <= HSQ_INDEX;
          end else if (plan_reg.ref_home && home_edge
                       && (home_sw ^ plan_reg.edge_right)) begin
            state_reg <= plan_reg.uses_index ? HSQ_INDEX : HSQ_DONE;
          end else if (fwd_lim) begin
            if (plan_reg.on_block) begin
              blk_run_reg <= 1'b1;
              state_reg   <= HSQ_BLOCK;
            end else if (plan_reg.ref_limit) begin
              state_reg <= plan_reg.uses_index ? HSQ_INDEX : HSQ_DONE;
            end else begin
              plan_reg.dir_pos <= !plan_reg.dir_pos;
              state_reg <= HSQ_BACK;
            end
          end
        end
        HSQ_BLOCK: begin
          if (abort) begin
            blk_run_reg <= 1'b0;
            state_reg   <= HSQ_IDLE;
          end else if (blk_expired) begin
            blk_run_reg <= 1'b0;
            if (plan_reg.ref_limit) begin
              state_reg <= plan_reg.uses_index ? HSQ_INDEX : HSQ_DONE;
            end else begin
              plan_reg.dir_pos <= !plan_reg.dir_pos;
              state_reg <= HSQ_BACK;
            end
          end
        end
        HSQ_BACK: begin
          if (abort) begin
            state_reg <= HSQ_IDLE;
          end else if (home_edge) begin
            state_reg <= plan_reg.uses_index ? HSQ_INDEX : HSQ_DONE;
          end
        end
        HSQ_INDEX: begin
          if (abort) begin
            state_reg <= HSQ_IDLE;
          end else if (sense_in.index_pulse) begin
            state_reg <= HSQ_DONE;
          end
        end
        HSQ_DONE: begin
          if (abort) begin
            state_reg <= HSQ_IDLE;
          end
        end
        HSQ_ERROR: begin
          if (!start_lvl) begin
            state_reg <= HSQ_IDLE;
          end
        end
        default: state_reg <= HSQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Speed ramp and position counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      target_speed_reg <= 32'sh0;
    end else if (state_reg == HSQ_INDEX || state_reg == HSQ_BACK) begin
      target_speed_reg <= plan_reg.dir_pos ? $signed(spd_zero_reg)
                          : -$signed(spd_zero_reg);
    end else if (state_reg == HSQ_BLOCK
                 || state_reg == HSQ_SEARCH && plan_ok
                    && (plan_reg.ref_limit || plan_reg.ref_home)) begin
      target_speed_reg <= plan_reg.dir_pos ? $signed(spd_switch_reg)
                          : -$signed(spd_switch_reg);
    end else begin
      target_speed_reg <= 32'sh0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      speed_out <= 32'sh0;
    end else if (speed_out < target_speed_reg) begin
      speed_out <= (target_speed_reg - speed_out > $signed(homing_accel_reg))
                   ? speed_out + $signed(homing_accel_reg)
                   : target_speed_reg;
    end else if (speed_out > target_speed_reg) begin
      speed_out <= (speed_out - target_speed_reg > $signed(homing_accel_reg))
                   ? speed_out - $signed(homing_accel_reg)
                   : target_speed_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      position_out <= 32'sh0;
    end else if (ref_hit) begin
      position_out <= home_offset_reg;
    end else if (step_in) begin
      position_out <= plan_reg.dir_pos ? position_out + 32'sh1
                      : position_out - 32'sh1;
    end
  end

  // ----------------------------------------------------------------------
  // Status code
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ever_homed_reg <= 1'b0;
    end else if (state_reg == HSQ_DONE) begin
      ever_homed_reg <= 1'b1;
    end else if (state_reg == HSQ_ERROR) begin
      ever_homed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_reg  <= 3'h1;
      homed_out <= 1'b0;
    end else begin
      homed_out <= state_reg == HSQ_DONE && at_rest;
      case (state_reg)
        HSQ_SEARCH, HSQ_BACK, HSQ_INDEX, HSQ_BLOCK: code_reg <= 3'h0;
        HSQ_DONE:  code_reg <= (at_rest && (op_enabled_in || cur_pos))
                               ? 3'h3 : 3'h2;
        HSQ_ERROR: code_reg <= standstill ? 3'h5 : 3'h4;
        HSQ_IDLE:  code_reg <= ever_homed_reg ? 3'h2 : 3'h1;
        default:   code_reg <= 3'h1;
      endcase
    end
  end

endmodule

// >>> testbench/hsq_homing_props.sv
// Checker of the homing sequencer bus and status ports.
// Assumes it is bound to the homing top module.
`timescale 1ns/1ps
module hsq_homing_props (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               psel_in,
  input wire logic               penable_in,
  input wire logic [7:0]         paddr_in,
  input wire logic [31:0]        prdata_out,
  input wire logic               pready_out,
  input wire logic               pslverr_out,
  input wire logic signed [31:0] speed_out,
  input wire logic               homed_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_setup_answer: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_idle_no_ready: assert property (!(psel_in && !penable_in) |=> !pready_out)
    else $error("ready without setup");
  a_err_reads_zero: assert property (pslverr_out |-> pready_out && prdata_out == 0)
    else $error("error without ready or nonzero data");
  a_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 8'h2C
    |=> pslverr_out) else $error("unmapped address not refused");
  a_mapped_ok: assert property (psel_in && !penable_in && paddr_in <= 8'h2C
    && paddr_in[1:0] == 2'h0 |=> !pslverr_out) else $error("mapped refused");
  a_homed_still: assert property (homed_out |-> speed_out == 0)
    else $error("moving while homed");
  a_homed_hold: assert property ($rose(homed_out) |=> homed_out)
    else $error("homed dropped at once");
endmodule
bind hsq_homing hsq_homing_props hsq_homing_props_inst (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .speed_out(speed_out), .homed_out(homed_out));

// >>> testbench/hsq_motor_model.sv
// Motor, switches and encoder index beside the homing sequencer.
// Assumes switch and block positions fixed on a step axis.
`timescale 1ns/1ps
module hsq_motor_model (
  input  wire logic               clk_in,
  input  wire logic signed [31:0] speed_in,
  output hsq_pkg::hsq_sense_type  sense_out,
  output logic [15:0]             current_out,
  output logic                    step_out
);
  import hsq_pkg::*;
  int         pos = 0;
  logic [1:0] tick = 2'h0;
  logic       idx = 1'b0;
  logic       dir_pos;
  logic       blocked;
  assign dir_pos = speed_in > 0;
  assign blocked = dir_pos ? pos >= 64 : pos <= -64;
  assign sense_out = '{home_sw: pos >= 20 && pos <= 40,
    neg_limit: pos <= -60, pos_limit: pos >= 60, index_pulse: idx};
  // Stalled against the block draws high current
  assign current_out = (blocked && speed_in != 0) ? 16'h0200 : 16'h0010;
  always @(posedge clk_in) begin
    tick <= tick + 2'h1;
    step_out <= 1'b0;
    idx <= 1'b0;
    if (speed_in != 0 && tick == 2'h0 && !blocked) begin
      pos <= dir_pos ? pos + 1 : pos - 1;
      step_out <= 1'b1;
      idx <= ((dir_pos ? pos + 1 : pos - 1) % 16) == 0;
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the homing sequencer.
// Assumes the motor model on the far side and APB from this bench.
`timescale 1ns/1ps
module tb_top;
  import hsq_pkg::*;
  typedef struct packed {
    logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;
  } hsq_reg_row_type;
  typedef struct packed {
    logic [7:0] m; logic [15:0] c; logic op; logic [31:0] k; logic [31:0] e;
    logic [31:0] p;
  } hsq_home_row_type;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic        pready_out, pslverr_out, step_in, homed_out, err, op_in = 0;
  logic [15:0] cur_in;
  logic [2:0]  mask_in = 3'h7;
  hsq_sense_type      sense_in;
  logic signed [31:0] speed_out, position_out;
  int num_errors = 0, compares = 0, cycles = 0;
  hsq_reg_row_type regs [11] = '{
    '{0, 8'h08, 0, 32'h400, 0}, '{0, 8'h1C, 0, 1, 0},
    '{0, 8'h20, 0, 32'hFFFF, 0}, '{1, 8'h00, 6, 6, 0},
    '{1, 8'h0C, 32'h1234, 32'h1234, 0}, '{1, 8'h14, 100, 100, 0},
    '{1, 8'h18, 32, 32, 0}, '{1, 8'h20, 256, 256, 0},
    '{1, 8'h24, 0, 0, 0}, '{1, 8'h08, 32'hFFFF, 32'h400, 0},
    '{1, 8'h40, 5, 0, 1}};
  hsq_home_row_type hom [6] = '{
    '{8'h23, 16'h10, 0, 32'h3400, 32'h1400, 32'h1234},
    '{8'h0F, 16'h10, 1, 32'h3000, 32'h2000, 0},
    '{8'hEF, 16'h10, 1, 32'h3000, 32'h2000, 0},
    '{8'h21, 16'h10, 1, 32'h3400, 32'h1400, 32'h1244},
    '{8'h11, 16'h10, 1, 32'h3400, 32'h1400, 32'h1270},
    '{8'hEF, 16'h11, 1, 32'h3400, 32'h1400, 32'h1274}};
  hsq_homing hsq_homing_inst (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sense_in(sense_in),
    .input_special_function_mask_in(mask_in), .motor_current_in(cur_in),
    .op_enabled_in(op_in), .step_in(step_in), .speed_out(speed_out),
    .position_out(position_out), .homed_out(homed_out));
  hsq_motor_model hsq_motor_model_inst (.clk_in(clk_in),
    .speed_in(speed_out), .sense_out(sense_in), .current_out(cur_in),
    .step_out(step_in));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 0;
    foreach (regs[i]) begin
      if (regs[i].wr) apb(1, regs[i].a, regs[i].d);
      apb(0, regs[i].a, 0);
      chk(rd, regs[i].e);
      chk({31'h0, err}, {31'h0, regs[i].er});
    end
    $display("register test done");
    foreach (hom[i]) begin
      op_in <= hom[i].op;
      apb(1, 8'h10, {{24{hom[i].m[7]}}, hom[i].m});
      apb(1, 8'h04, {16'h0, hom[i].c});
      do apb(0, 8'h08, 0);
      while ((rd & 32'h3400) !== 32'h1400 && rd[13] !== 1'b1);
      chk(rd & hom[i].k, hom[i].e);
      // Counter minus model position is fixed once the reference is taken
      if (hom[i].e == 32'h1400)
        chk(position_out - hsq_motor_model_inst.pos, hom[i].p);
      apb(1, 8'h04, 0);
      apb(0, 8'h08, 0);
      apb(0, 8'h08, 0);
      chk(rd & 32'h3400, hom[i].e[12] ? 32'h1000 : 32'h0400);
    end
    $display("homing test done");
    rst_in <= 1;
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    apb(0, 8'h08, 0);
    chk(rd & 32'h3400, 32'h0400);
    $display("restart test done");
    end_of_test();
  end
endmodule
